// file: dv/gior_core_model.sv
`timescale 1ns/1ps
module gior_core_model (
  input  wire logic       aclk,
  input  wire logic [3:0] word_req,
  input  wire logic       oe_req,
  output logic      [3:0] core_out_word,
  output logic            core_oe
);
  // Fabric flops launch on aclk, so requests land one cycle late
  always_ff @(posedge aclk) begin
    core_out_word <= word_req;
    core_oe       <= oe_req;
  end
endmodule

// file: dv/gior_top_tb_top.sv
`timescale 1ns/1ps
`include "gior_cfg.svh"
module gior_top_tb_top;
  logic        aclk, aresetn, ce, pad_ext, ic, oc, ct, oe_req, core_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pad_out, pad_oe, pu, pd;
  logic [1:0]  bresp, rresp;
  logic [3:0]  w_req, core_out, core_in;
  logic        pll;
  logic        rr [0:7];
  logic        ff [0:7];
  int          n_errors, checked;
  // Wire level: the pin driver wins over the outside source
  wire         pad_in = pad_oe ? pad_out : pad_ext;

  gior_top #(.SER_W(4)) dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pu), .pull_down_en(pd),
    .in_clk_pin(ic), .out_clk_pin(oc), .clk_tree(ct),
    .core_out_word(core_out), .core_oe(core_oe), .core_in_word(core_in),
    .pll_ref_out(pll));
  gior_core_model core_u (.aclk(aclk), .word_req(w_req), .oe_req(oe_req),
    .core_out_word(core_out), .core_oe(core_oe));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge aclk);
  endtask

  // A wait that runs out of its bound ends the run at once
  task automatic tmo(int n);
    if (n >= 40) begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    r = bresp;
    bready <= 1'b0;
    tmo(n);
    @(posedge aclk);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(n);
    @(posedge aclk);
  endtask

  // Control word with configuration done and the pin in use
  function automatic logic [31:0] ctl(int m, logic a, logic g, logic iv,
                                      logic de, int dm);
    return {16'h0, 2'h3, 2'h0, dm[1:0], de, iv, 2'h0, g, 1'h0, g, a, m[1:0]};
  endfunction

  // Word seen by the core after the falling capture of period k
  function automatic logic [1:0] ddr_in(int m, int k);
    if (m == 0) return {ff[k], rr[k]};
    if (m == 1) return {ff[k-1], rr[k]};
    return {ff[k-2], rr[k-1]};
  endfunction

  initial begin
    logic [31:0] d, v;
    logic [1:0]  r;
    logic        b, o, iv, e;
    n_errors = 0;
    checked = 0;
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, pad_ext, ic, oc, ct, oe_req, w_req} = '0;
    ce = 1'b1;
    void'($urandom(32'h1b47));
    step(10);
    aresetn <= 1'b1;
    step(2);
    chk("pull_up", pu, 1);
    chk("pad_oe", pad_oe, 0);
    rd(`GIOR_ADDR_CTRL, v, r);
    chk("ctrl_rst", v, 0);
    d = $urandom;
    wr(`GIOR_ADDR_CTRL, d, r);
    rd(`GIOR_ADDR_CTRL, v, r);
    chk("ctrl_rb", v, {16'h0, d[15:0]});
    wr(`GIOR_ADDR_STATUS, d, r);
    chk("st_wr", r, `GIOR_RESP_OKAY);
    wr(8'h08, d, r);
    chk("bad_wr", r, `GIOR_RESP_SLVERR);
    rd(8'h08, v, r);
    chk("bad_rd", v, 0);
    chk("bad_rd_resp", r, `GIOR_RESP_SLVERR);
    // Pull choice before done, then for an unused pin both ways
    for (int i = 0; i < 3; i++) begin
      wr(`GIOR_ADDR_CTRL, (i == 0) ? 0 : (i == 1) ? 32'h4000 : 32'h6000, r);
      step(2);
      chk("pull_up", pu, i < 2);
      chk("pull_dn", pd, i == 2);
      chk("unused_oe", pad_oe, 0);
    end
    // Unregistered paths in input, output and bidirectional modes
    for (int m = 0; m < 3; m++) begin
      iv = 1'($urandom);
      wr(`GIOR_ADDR_CTRL, ctl(m, 0, 0, iv, 0, 0), r);
      repeat (6) begin
        b = 1'($urandom);
        o = 1'($urandom);
        e = 1'($urandom);
        pad_ext <= e;
        w_req <= {3'h0, b};
        oe_req <= o;
        // Driven pad loops back through the core flop and three sync stages
        step(8);
        chk("sr_oe", pad_oe, m == 0 ? 0 : m == 1 ? 1 : o);
        if (m > 0) chk("sr_out", pad_out, b ^ iv);
        chk("sr_in", core_in[0],
            m == 1 ? 0 : (m == 2 && o) ? b ^ iv : e);
      end
    end
    // Alternate input, then clock forwarding
    wr(`GIOR_ADDR_CTRL, ctl(0, 1, 0, 0, 0, 0), r);
    repeat (4) begin
      e = 1'($urandom);
      pad_ext <= e;
      step(6);
      chk("alt", pll, e);
      chk("alt_core", core_in, 0);
    end
    rd(`GIOR_ADDR_STATUS, v, r);
    chk("status", v, {26'h0, e, e, 4'h0});
    // Clock enable low must freeze the alternate route too
    ce <= 1'b0;
    pad_ext <= ~e;
    step(6);
    chk("ce_hold", pll, e);
    ce <= 1'b1;
    wr(`GIOR_ADDR_CTRL, ctl(3, 0, 0, 0, 0, 0), r);
    repeat (4) begin
      e = 1'($urandom);
      ct <= e;
      step(3);
      chk("clk_out", {pad_oe, pad_out}, {1'b1, e});
    end
    // Double rate, normal, resync and pipe alignment, receive then transmit
    for (int m = 0; m < 3; m++) for (int dir = 0; dir < 2; dir++) begin
      iv = 1'($urandom);
      wr(`GIOR_ADDR_CTRL, ctl(dir, 0, 1, iv, 1, m), r);
      for (int k = 0; k < 8; k++) begin
        rr[k] = 1'($urandom);
        ff[k] = 1'($urandom);
        pad_ext <= rr[k];
        w_req <= {2'h0, ff[k], rr[k]};
        step(4);
        ic <= 1'b1;
        oc <= 1'b1;
        step(6);
        if (dir && k > 1)
          chk("ddr_hi", pad_out, (m == 2 ? rr[k-1] : rr[k]) ^ iv);
        pad_ext <= ff[k];
        step(4);
        ic <= 1'b0;
        oc <= 1'b0;
        step(6);
        if (dir && k > 1)
          chk("ddr_lo", pad_out, (m == 2 ? ff[k-1] : ff[k]) ^ iv);
        if (!dir && k > 1)
          chk("ddr_in", core_in[1:0], ddr_in(m, k));
        step(2);
      end
    end
    // Registered single rate paths, each on the edge it selects
    for (int m = 0; m < 3; m += 2) begin
      v = $urandom & 32'hD0;
      wr(`GIOR_ADDR_CTRL, ctl(m, 0, 1, 0, 0, 0) | v, r);
      repeat (4) begin
        d = $urandom;
        pad_ext <= d[0];
        w_req <= {3'h0, d[1]};
        oe_req <= d[2];
        step(4);
        {ic, oc} <= 2'h3;
        step(6);
        pad_ext <= d[3];
        w_req <= {3'h0, d[4]};
        oe_req <= d[5];
        step(4);
        {ic, oc} <= 2'h0;
        step(8);
        if (m == 0) chk("reg_in", core_in[0], v[4] ? d[3] : d[0]);
        if (m == 2) chk("reg_out", pad_out, v[6] ? d[4] : d[1]);
        if (m == 2) chk("reg_oe", pad_oe, v[7] ? d[5] : d[2]);
      end
    end
    // Four bit serial lanes, earliest bit in bit zero both ways
    for (int dir = 0; dir < 2; dir++) begin
      iv = 1'($urandom);
      wr(`GIOR_ADDR_CTRL, ctl(dir, 0, 0, iv, 0, 0) | 32'h1000, r);
      repeat (2) begin
        v = $urandom;
        w_req <= v[3:0];
        for (int j = 0; j < 4; j++) begin
          pad_ext <= v[j];
          step(4);
          {ic, oc} <= 2'h3;
          step(6);
          if (dir) chk("ser", pad_out, v[j] ^ iv);
          {ic, oc} <= 2'h0;
          step(10);
        end
        if (!dir) chk("deser", core_in, v[3:0]);
      end
    end
    complete_run();
  end
endmodule

// file: rtl/gior_cfg.svh
`ifndef GIOR_CFG_SVH
`define GIOR_CFG_SVH
// Register byte offsets
`define GIOR_ADDR_CTRL     8'h00
`define GIOR_ADDR_STATUS   8'h04
// Control field positions
`define GIOR_F_MODE_LSB    0
`define GIOR_F_MODE_MSB    1
`define GIOR_F_ALT         2
`define GIOR_F_IN_REG      3
`define GIOR_F_IN_FALL     4
`define GIOR_F_OUT_REG     5
`define GIOR_F_OUT_FALL    6
`define GIOR_F_OE_FALL     7
`define GIOR_F_INV         8
`define GIOR_F_DDR_EN      9
`define GIOR_F_DDR_LSB     10
`define GIOR_F_DDR_MSB     11
`define GIOR_F_SERDES      12
`define GIOR_F_PULL_DN     13
`define GIOR_F_DONE        14
`define GIOR_F_USED        15
// Reset values and bus answers
`define GIOR_CTRL_RST      16'h0000
`define GIOR_RESP_OKAY     2'h0
`define GIOR_RESP_SLVERR   2'h2
`endif

// file: rtl/gior_pkg.sv
package gior_pkg;
  typedef enum logic [1:0] {
    GIOR_MODE_INPUT,
    GIOR_MODE_OUTPUT,
    GIOR_MODE_BIDIR,
    GIOR_MODE_CLKOUT
  } gior_mode_t;
  typedef enum logic [1:0] {
    GIOR_DDR_NORMAL,
    GIOR_DDR_RESYNC,
    GIOR_DDR_PIPE,
    GIOR_DDR_SPARE
  } gior_ddr_t;
  typedef struct packed {
    logic [15:0] ctrl;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  core_in;
    logic        fall_cap;
    logic [1:0]  pipe_in;
    logic [1:0]  out_word;
    logic [1:0]  pipe_out;
    logic        pad_out;
    logic        pad_oe;
    logic        pull_up;
    logic        pull_dn;
    logic        alt;
  } gior_top_state_t;
endpackage

// file: rtl/gior_serdes.sv
`timescale 1ns/1ps
module gior_serdes #(
  parameter int N = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         in_step,
  input  wire logic         in_bit,
  input  wire logic         out_step,
  input  wire logic [N-1:0] word_in,
  output logic      [N-1:0] word_out,
  output logic              word_ready,
  output logic              ser_bit
);
  localparam int CW = $clog2(N);
  typedef struct packed {
    logic [N-1:0]  dsh;
    logic [CW-1:0] dcnt;
    logic [N-1:0]  dword;
    logic          dready;
    logic [N-1:0]  ssh;
    logic [CW-1:0] scnt;
    logic          sbit;
  } gior_serdes_state_t;

  gior_serdes_state_t st_reg;
  gior_serdes_state_t st_next;
  logic [N-1:0]       shifted;

  // Earliest bit drifts to bit 0 as later bits enter at the top
  always_comb begin
    st_next = st_reg;
    shifted = {in_bit, st_reg.dsh[N-1:1]};
    if (ce) begin
      st_next.dready = 1'b0;
      if (in_step) begin
        st_next.dsh  = shifted;
        st_next.dcnt = st_reg.dcnt + 1'b1;
        if (st_reg.dcnt == CW'(N-1)) begin
          st_next.dword  = shifted;
          st_next.dready = 1'b1;
          st_next.dcnt   = '0;
        end
      end
      if (out_step) begin
        st_next.scnt = st_reg.scnt + 1'b1;
        if (st_reg.scnt == '0) begin
          st_next.sbit = word_in[0];
          st_next.ssh  = word_in >> 1;
        end else begin
          st_next.sbit = st_reg.ssh[0];
          st_next.ssh  = st_reg.ssh >> 1;
        end
        if (st_reg.scnt == CW'(N-1)) begin
          st_next.scnt = '0;
        end
      end
    end
  end

  // Synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign word_out   = st_reg.dword;
  assign word_ready = st_reg.dready;
  assign ser_bit    = st_reg.sbit;

  AST_DESER_LAST: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && in_step && st_reg.dcnt == CW'(N-1)
    |=> word_ready && word_out[N-1] == $past(in_bit))
    else $error("deserializer last bit misplaced");
  AST_SER_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && out_step && st_reg.scnt == '0
    |=> ser_bit == $past(word_in[0]))
    else $error("serializer first bit wrong");
endmodule

// file: rtl/gior_sync.sv
`timescale 1ns/1ps
module gior_sync #(
  parameter int W = 3
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } gior_sync_state_t;

  gior_sync_state_t st_reg;
  gior_sync_state_t st_next;

  // Edges come from s2 against s3 so that s1 feeds only s2
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.s1   = async_in;
      st_next.s2   = st_reg.s1;
      st_next.s3   = st_reg.s2;
      st_next.rise = st_reg.s2 & ~st_reg.s3;
      st_next.fall = ~st_reg.s2 & st_reg.s3;
    end
  end

  // Synchronous reset clears all stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lvl  = st_reg.s3;
  assign rise = st_reg.rise;
  assign fall = st_reg.fall;
endmodule

// file: rtl/gior_top.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "gior_cfg.svh"
module gior_top
  import gior_pkg::*;
#(
  parameter int SER_W = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             pad_in,
  output logic                  pad_out,
  output logic                  pad_oe,
  output logic                  pull_up_en,
  output logic                  pull_down_en,
  input  wire logic             in_clk_pin,
  input  wire logic             out_clk_pin,
  input  wire logic             clk_tree,
  input  wire logic [SER_W-1:0] core_out_word,
  input  wire logic             core_oe,
  output logic      [SER_W-1:0] core_in_word,
  output logic                  pll_ref_out
);
  import gior_pkg::*;

  gior_top_state_t  st_reg;
  gior_top_state_t  st_next;
  logic [2:0]       sy_lvl;
  logic [2:0]       sy_rise;
  logic [2:0]       sy_fall;
  logic [SER_W-1:0] deser_word;
  logic             deser_ready;
  logic             ser_bit;
  logic             pad_lvl;
  logic             in_rise;
  logic             in_fall;
  logic             out_rise;
  logic             out_fall;
  gior_mode_t       mode;
  gior_ddr_t        ddr;
  logic             cfg_done;
  logic             used;
  logic             en_user;
  logic             in_path;
  logic             out_path;
  logic             alt_path;
  logic             ddr_on;
  logic             serdes_on;
  logic             inv;
  logic             in_ev;
  logic             out_ev;
  logic             oe_ev;
  logic             rise_output_bit;
  logic             fall_output_bit;

  // Pad and both pin clocks are foreign to aclk, so all pass three flops
  gior_sync #(
    .W (3)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .async_in ({out_clk_pin, in_clk_pin, pad_in}),
    .lvl      (sy_lvl),
    .rise     (sy_rise),
    .fall     (sy_fall)
  );

  // Serial lanes step on rising pin clock edges only
  gior_serdes #(
    .N (SER_W)
  ) u_serdes (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .in_step    (serdes_on && in_path && in_rise),
    .in_bit     (pad_lvl),
    .out_step   (serdes_on && out_path && out_rise),
    .word_in    (core_out_word),
    .word_out   (deser_word),
    .word_ready (deser_ready),
    .ser_bit    (ser_bit)
  );

  // Decoded configuration fields
  assign pad_lvl   = sy_lvl[0];
  assign in_rise   = sy_rise[1];
  assign in_fall   = sy_fall[1];
  assign out_rise  = sy_rise[2];
  assign out_fall  = sy_fall[2];
  assign mode      = gior_mode_t'(st_reg.ctrl[`GIOR_F_MODE_MSB:
                                              `GIOR_F_MODE_LSB]);
  assign ddr       = gior_ddr_t'(st_reg.ctrl[`GIOR_F_DDR_MSB:
                                             `GIOR_F_DDR_LSB]);
  assign cfg_done  = st_reg.ctrl[`GIOR_F_DONE];
  assign used      = st_reg.ctrl[`GIOR_F_USED];
  assign en_user   = cfg_done && used;
  assign alt_path  = en_user && mode == GIOR_MODE_INPUT
                     && st_reg.ctrl[`GIOR_F_ALT];
  assign in_path   = en_user && !alt_path
                     && (mode == GIOR_MODE_INPUT || mode == GIOR_MODE_BIDIR);
  assign out_path  = en_user
                     && (mode == GIOR_MODE_OUTPUT || mode == GIOR_MODE_BIDIR);
  assign ddr_on    = st_reg.ctrl[`GIOR_F_DDR_EN];
  // Serdes is full rate only, so double rate takes precedence
  assign serdes_on = st_reg.ctrl[`GIOR_F_SERDES] && !ddr_on;
  assign inv       = st_reg.ctrl[`GIOR_F_INV];
  assign in_ev     = st_reg.ctrl[`GIOR_F_IN_FALL] ? in_fall : in_rise;
  assign out_ev    = st_reg.ctrl[`GIOR_F_OUT_FALL] ? out_fall : out_rise;
  assign oe_ev     = st_reg.ctrl[`GIOR_F_OE_FALL] ? out_fall : out_rise;
  assign rise_output_bit = core_out_word[0];
  assign fall_output_bit = core_out_word[1];

  // Register bus, receive path and transmit path in one next-state process
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      // Write address and data are taken in either order
      if (s_axi_awvalid && st_reg.awready) begin
        st_next.aw_got = 1'b1;
        st_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.wready) begin
        st_next.w_got = 1'b1;
        st_next.wdata = s_axi_wdata;
        st_next.wstrb = s_axi_wstrb;
      end
      if (st_reg.bvalid && s_axi_bready) begin
        st_next.bvalid = 1'b0;
      end
      if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
        st_next.aw_got = 1'b0;
        st_next.w_got  = 1'b0;
        st_next.bvalid = 1'b1;
        st_next.bresp  = `GIOR_RESP_OKAY;
        if (st_reg.awaddr == `GIOR_ADDR_CTRL) begin
          if (st_reg.wstrb[0]) begin
            st_next.ctrl[7:0] = st_reg.wdata[7:0];
          end
          if (st_reg.wstrb[1]) begin
            st_next.ctrl[15:8] = st_reg.wdata[15:8];
          end
        end else if (st_reg.awaddr != `GIOR_ADDR_STATUS) begin
          st_next.bresp = `GIOR_RESP_SLVERR;
        end
      end
      st_next.awready = !st_next.aw_got;
      st_next.wready  = !st_next.w_got;

      // Read answers one cycle after the address is taken
      if (s_axi_arvalid && st_reg.arready) begin
        st_next.arready = 1'b0;
        st_next.rvalid  = 1'b1;
        st_next.rresp   = `GIOR_RESP_OKAY;
        if (s_axi_araddr == `GIOR_ADDR_CTRL) begin
          st_next.rdata = {16'h0000, st_reg.ctrl};
        end else if (s_axi_araddr == `GIOR_ADDR_STATUS) begin
          st_next.rdata = {26'h0000000, st_reg.alt, pad_lvl,
                           st_reg.core_in[3:0]};
        end else begin
          st_next.rdata = 32'h00000000;
          st_next.rresp = `GIOR_RESP_SLVERR;
        end
      end else if (st_reg.rvalid && s_axi_rready) begin
        st_next.rvalid  = 1'b0;
        st_next.arready = 1'b1;
      end

      // Alternate route skips the core word entirely
      st_next.alt = alt_path ? pad_lvl : 1'b0;

      // Receive path
      if (!in_path) begin
        st_next.core_in  = '0;
        st_next.fall_cap = 1'b0;
        st_next.pipe_in  = '0;
      end else if (serdes_on) begin
        if (deser_ready) begin
          st_next.core_in = deser_word;
        end
      end else if (ddr_on) begin
        st_next.core_in[3:2] = 2'h0;
        case (ddr)
          GIOR_DDR_NORMAL: begin
            if (in_rise) begin
              st_next.core_in[0] = pad_lvl;
            end
            if (in_fall) begin
              st_next.core_in[1] = pad_lvl;
            end
          end
          GIOR_DDR_RESYNC: begin
            if (in_fall) begin
              st_next.fall_cap = pad_lvl;
            end
            if (in_rise) begin
              st_next.core_in[1:0] = {st_reg.fall_cap, pad_lvl};
            end
          end
          default: begin
            if (in_fall) begin
              st_next.fall_cap = pad_lvl;
            end
            if (in_rise) begin
              st_next.pipe_in      = {st_reg.fall_cap, pad_lvl};
              st_next.core_in[1:0] = st_reg.pipe_in;
            end
          end
        endcase
      end else if (st_reg.ctrl[`GIOR_F_IN_REG]) begin
        st_next.core_in[3:1] = 3'h0;
        if (in_ev) begin
          st_next.core_in[0] = pad_lvl;
        end
      end else begin
        st_next.core_in = {3'h0, pad_lvl};
      end

      // Transmit path
      if (en_user && mode == GIOR_MODE_CLKOUT) begin
        st_next.pad_out = clk_tree;
        st_next.pad_oe  = 1'b1;
      end else if (!out_path) begin
        st_next.pad_out  = 1'b0;
        st_next.pad_oe   = 1'b0;
        st_next.out_word = '0;
        st_next.pipe_out = '0;
      end else begin
        if (serdes_on) begin
          st_next.pad_out = ser_bit ^ inv;
        end else if (ddr_on) begin
          case (ddr)
            GIOR_DDR_NORMAL: begin
              if (out_rise) begin
                st_next.pad_out = rise_output_bit ^ inv;
              end
              if (out_fall) begin
                st_next.pad_out = fall_output_bit ^ inv;
              end
            end
            GIOR_DDR_RESYNC: begin
              if (out_rise) begin
                st_next.out_word = core_out_word[1:0];
                st_next.pad_out  = rise_output_bit ^ inv;
              end
              if (out_fall) begin
                st_next.pad_out = st_reg.out_word[1] ^ inv;
              end
            end
            default: begin
              if (out_rise) begin
                st_next.pipe_out = core_out_word[1:0];
                st_next.out_word = st_reg.pipe_out;
                st_next.pad_out  = st_reg.pipe_out[0] ^ inv;
              end
              if (out_fall) begin
                st_next.pad_out = st_reg.out_word[1] ^ inv;
              end
            end
          endcase
        end else if (st_reg.ctrl[`GIOR_F_OUT_REG]) begin
          if (out_ev) begin
            st_next.pad_out = rise_output_bit ^ inv;
          end
        end else begin
          st_next.pad_out = rise_output_bit ^ inv;
        end
        // Enable register shares the output clock but has its own edge
        if (mode == GIOR_MODE_OUTPUT) begin
          st_next.pad_oe = 1'b1;
        end else if (st_reg.ctrl[`GIOR_F_OUT_REG]) begin
          if (oe_ev) begin
            st_next.pad_oe = core_oe;
          end
        end else begin
          st_next.pad_oe = core_oe;
        end
      end

      // Pulls override everything until the pin is in use
      st_next.pull_up = 1'b0;
      st_next.pull_dn = 1'b0;
      if (!cfg_done) begin
        st_next.pull_up = 1'b1;
        st_next.pad_oe  = 1'b0;
      end else if (!used) begin
        st_next.pull_up = !st_reg.ctrl[`GIOR_F_PULL_DN];
        st_next.pull_dn = st_reg.ctrl[`GIOR_F_PULL_DN];
        st_next.pad_oe  = 1'b0;
      end
    end
  end

  // Synchronous reset puts the pin in its configuration state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg         <= '0;
      st_reg.ctrl    <= `GIOR_CTRL_RST;
      st_reg.awready <= 1'b1;
      st_reg.wready  <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.pull_up <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output straight from the state register
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign pad_out       = st_reg.pad_out;
  assign pad_oe        = st_reg.pad_oe;
  assign pull_up_en    = st_reg.pull_up;
  assign pull_down_en  = st_reg.pull_dn;
  assign core_in_word  = st_reg.core_in;
  assign pll_ref_out   = st_reg.alt;

  // Step sequences for the double rate checks
  sequence s_resync_rise;
    ce && in_path && ddr_on && !serdes_on && ddr == GIOR_DDR_RESYNC
    && in_rise;
  endsequence
  sequence s_pipe_rise;
    ce && in_path && ddr_on && !serdes_on && ddr == GIOR_DDR_PIPE
    && in_rise;
  endsequence

  AST_CFG_PULLUP: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !cfg_done |=> pull_up_en && !pad_oe && !pull_down_en)
    else $error("no pull-up while configuring");
  AST_UNUSED_PULL: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cfg_done && !used |=> !pad_oe
    && pull_down_en == $past(st_reg.ctrl[`GIOR_F_PULL_DN])
    && pull_up_en != pull_down_en)
    else $error("unused pin pull wrong");
  AST_INPUT_NO_DRIVE: assert property (@(posedge aclk)
    disable iff (!aresetn)
    ce && en_user && mode == GIOR_MODE_INPUT |=> !pad_oe)
    else $error("input mode drives pad");
  AST_ALT_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && alt_path |=> pll_ref_out == $past(pad_lvl)
    && core_in_word == '0)
    else $error("alternate input not passed");
  AST_CLK_FWD: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && en_user && mode == GIOR_MODE_CLKOUT
    |=> pad_oe && pad_out == $past(clk_tree))
    else $error("clock not forwarded");
  AST_RESYNC_PAIR: assert property (@(posedge aclk) disable iff (!aresetn)
    s_resync_rise |=> core_in_word[1:0]
    == {$past(st_reg.fall_cap), $past(pad_lvl)})
    else $error("resync pair wrong");
  AST_PIPE_LAT: assert property (@(posedge aclk) disable iff (!aresetn)
    s_pipe_rise |=> core_in_word[1:0] == $past(st_reg.pipe_in)
    && st_reg.pipe_in == {$past(st_reg.fall_cap), $past(pad_lvl)})
    else $error("pipeline stage missing");
  AST_OUT_INV: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cfg_done && out_path && !ddr_on && !serdes_on
    && !st_reg.ctrl[`GIOR_F_OUT_REG]
    |=> pad_out == ($past(core_out_word[0]) ^ $past(inv)))
    else $error("output inversion wrong");
  AST_OE_FOLLOW: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cfg_done && out_path && mode == GIOR_MODE_BIDIR
    && !st_reg.ctrl[`GIOR_F_OUT_REG] |=> pad_oe == $past(core_oe))
    else $error("enable does not follow core");
endmodule
